/* File: verilog/cascade_timer_pkg.sv */
// Constants for the cascaded timer and watchdog block
`default_nettype none
package cascade_timer_pkg;
    // --------------------------------------------------------------
    // Clock and machine-cycle timing
    // --------------------------------------------------------------
    localparam int OSC_PER_MC = 12; // Oscillator periods per machine cycle
    localparam logic [3:0] PH_LAST = 4'(OSC_PER_MC - 1); // Final phase
    localparam logic [3:0] PH_INC = 4'h4; // Increment phase slot
    localparam logic [3:0] PH_FLAG = 4'h8; // Flag phase slot
    localparam logic [3:0] PH_SAMPLE = 4'h9; // Sample phase slot
    localparam logic [2:0] WD_RESET_MC = 3'h5; // Reset length, cycles
    // --------------------------------------------------------------
    // Register byte offsets
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_IO_CONFIG = 8'h00; // io_config_reg
    localparam logic [7:0] OFS_TIMER_MODE = 8'h04; // timer_mode_reg
    localparam logic [7:0] OFS_POWER_CTRL = 8'h08; // Run bits, power
    localparam logic [7:0] OFS_COUNT_LOW = 8'h0C; // Low counter
    localparam logic [7:0] OFS_COUNT_HIGH = 8'h10; // High counter
    localparam logic [7:0] OFS_STATUS = 8'h14; // Sticky events
    localparam logic [7:0] OFS_MASK = 8'h18; // Interrupt mask
    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int BIT_CASCADE = 6; // cascade_enable
    localparam int BIT_WATCHDOG = 7; // watchdog_enable
    localparam int BIT_RUN_LOW = 0; // run_bit_low
    localparam int BIT_RUN_HIGH = 1; // run_bit_high
    localparam int BIT_POWER_DOWN = 2; // power_down_bit
    localparam int BIT_SEL_LOW = 2; // count_select_low in mode reg
    localparam int BIT_SEL_HIGH = 6; // count select of high timer
    localparam int ST_OVF_LOW = 0; // overflow_flag_low
    localparam int ST_OVF_HIGH = 1; // overflow_flag_high
    localparam int ST_WD_RESET = 2; // Watchdog reset happened
    localparam logic [7:0] CFG_RESET = 8'h00; // Reset value, 8-bit regs
    // --------------------------------------------------------------
    // Timer modes, bus responses, watchdog states
    // --------------------------------------------------------------
    localparam logic [1:0] MODE_13 = 2'h0; // 13-bit prescaled
    localparam logic [1:0] MODE_8 = 2'h2; // 8-bit auto-reload
    localparam logic [1:0] RESP_OKAY = 2'h0; // AXI OKAY
    localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI SLVERR
    typedef enum logic [2:0] {
        WD_IDLE = 3'b001,
        WD_ARMED = 3'b010,
        WD_RESET = 3'b100
    } wd_state_t;
endpackage
`default_nettype wire

/* File: verilog/cascaded_timer_watchdog.sv */
// Cascaded 32-bit timer/counter with watchdog, AXI4-Lite registers
// Notes on behaviour
// - Cascade chains low timer under high timer
// - Cascade bit set runs, cleared stops
// - Cleared cascade reverts to per-timer run bits
// - Cascade timer steps once per machine cycle
// - Low carry bumps high; wrap sets high flag
// - Overflow rate set by preloaded count value
// - Count input sampled once per machine cycle
// - Count only on sampled high-then-low transition
// - Watchdog bit turns high overflow into reset
// - Watchdog counts cycles or external edges
// - High flag, then five-cycle reset next cycle
// - Watchdog reset clears registers like hardware reset; status keeps its watchdog-reset flag set
// - Power-down keeps external counting alive
// - Power-down overflow interrupts, or resets if watchdog
// - Counter overflow wakes from power-down
// - Cascade enable at config bit six
// - Watchdog enable at config bit seven
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`default_nettype none
module cascaded_timer_watchdog #(
    parameter int COUNT_W = 16 // Width of each timer half
) (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic COUNT_IN_LOW,
    input wire logic COUNT_IN_HIGH,
    output logic IRQ,
    output logic WDOG_RESET,
    output logic POWER_DOWN
);
    import cascade_timer_pkg::*;

    // --------------------------------------------------------------
    // Functions
    // --------------------------------------------------------------
    // Mapped register check, shared by read and write paths
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == OFS_IO_CONFIG) || (a == OFS_TIMER_MODE) ||
                  (a == OFS_POWER_CTRL) || (a == OFS_COUNT_LOW) ||
                  (a == OFS_COUNT_HIGH) || (a == OFS_STATUS) ||
                  (a == OFS_MASK);
    endfunction

    // Byte-lane merge of write data into an old value
    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        merge = r;
    endfunction

    // One step of a single timer; top bit is the overflow
    function automatic logic [16:0] step(input logic [15:0] v,
                                         input logic [1:0] m);
        logic [13:0] s13;
        logic [8:0] s8;
        logic [16:0] r;
        s13 = {1'b0, v[15:8], v[4:0]} + 14'h0001;
        s8 = {1'b0, v[7:0]} + 9'h001;
        case (m)
            MODE_13: begin // Prescaler in low five bits
                r = {s13[13], s13[12:5], v[7:5], s13[4:0]};
            end
            MODE_8: begin // Reload low byte from high byte
                r = s8[8] ? {1'b1, v[15:8], v[15:8]}
                          : {1'b0, v[15:8], s8[7:0]};
            end
            default: begin // Plain 16-bit count
                r = {1'b0, v} + 17'h00001;
            end
        endcase
        step = r;
    endfunction

    // --------------------------------------------------------------
    // Declarations
    // --------------------------------------------------------------
    logic [3:0] phase; // Oscillator phase within machine cycle
    logic tick_inc, tick_flag, tick_sample, tick_end; // Phase strobes
    wd_state_t wd_state, next_wd; // Watchdog sequencer
    logic [2:0] wd_cnt; // Machine cycles spent in reset
    logic soft_rst; // Hardware or watchdog reset
    logic [7:0] io_cfg; // io_config_reg contents
    logic [7:0] tmode; // timer_mode_reg contents
    logic run_low, run_high, pdn; // Run bits and power-down
    logic [COUNT_W-1:0] cnt_low, cnt_high; // Timer halves
    logic samp_low, samp_high; // Last input samples
    logic edge_low, edge_high; // Falling edge seen, pending
    logic ovp_low, ovp_high; // Overflow waiting for flag phase
    logic [2:0] status, next_status, mask; // Events and mask
    logic aw_hold, w_hold; // Write address / data captured
    logic [7:0] waddr; // Captured write address
    logic [31:0] wdata; // Captured write data
    logic [3:0] wstrb; // Captured strobes
    logic wr_go; // Write performed this cycle
    logic [31:0] rd_mux; // Read data for ARADDR
    logic cas_en, wd_en, sel_low, sel_high; // Decoded controls
    logic adv_low, adv_high, adv_cas; // Advance requests
    logic [16:0] step_low, step_high; // Single-timer next values
    logic [32:0] sum32; // Cascade next value with carry

    assign soft_rst = SYS_RST | (wd_state == WD_RESET);
    assign cas_en = io_cfg[BIT_CASCADE];
    assign wd_en = io_cfg[BIT_WATCHDOG];
    assign sel_low = tmode[BIT_SEL_LOW];
    assign sel_high = tmode[BIT_SEL_HIGH];
    assign wr_go = aw_hold & w_hold & ~S_AXI_BVALID;

    // --------------------------------------------------------------
    // Machine-cycle phase
    // --------------------------------------------------------------
    // Twelve-phase counter, one machine cycle per wrap
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            phase <= 4'h0;
        end else if (phase == PH_LAST) begin
            phase <= 4'h0;
        end else begin
            phase <= phase + 4'h1;
        end
    end

    assign tick_inc = (phase == PH_INC);
    assign tick_flag = (phase == PH_FLAG);
    assign tick_sample = (phase == PH_SAMPLE);
    assign tick_end = (phase == PH_LAST);

    // --------------------------------------------------------------
    // Count inputs
    // --------------------------------------------------------------
    // Sample inputs; high then low sample marks one count
    always_ff @(posedge CLK_SYS) begin
        if (soft_rst) begin
            samp_low <= 1'b0;
            samp_high <= 1'b0;
            edge_low <= 1'b0;
            edge_high <= 1'b0;
        end else if (tick_sample) begin
            samp_low <= COUNT_IN_LOW;
            samp_high <= COUNT_IN_HIGH;
            edge_low <= samp_low & ~COUNT_IN_LOW;
            edge_high <= samp_high & ~COUNT_IN_HIGH;
        end else if (tick_inc) begin // Edge consumed by count
            edge_low <= 1'b0;
            edge_high <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // Counting
    // --------------------------------------------------------------
    // Timer select stalls in power-down; counter select keeps going
    assign adv_cas = sel_low ? edge_low : ~pdn;
    assign adv_low = run_low & (sel_low ? edge_low : ~pdn);
    assign adv_high = run_high & (sel_high ? edge_high : ~pdn);
    assign step_low = step(cnt_low, tmode[1:0]);
    assign step_high = step(cnt_high, tmode[5:4]);
    assign sum32 = {1'b0, cnt_high, cnt_low} + 33'h000000001;

    // Counter halves, software writes override counting
    always_ff @(posedge CLK_SYS) begin
        if (soft_rst) begin
            cnt_low <= '0;
            cnt_high <= '0;
            ovp_low <= 1'b0;
            ovp_high <= 1'b0;
        end else begin
            if (tick_flag) begin // Pending overflows handed to flags
                ovp_low <= 1'b0;
                ovp_high <= 1'b0;
            end
            if (tick_inc) begin
                if (cas_en) begin
                    if (adv_cas) begin
                        cnt_low <= sum32[COUNT_W-1:0];
                        cnt_high <= sum32[2*COUNT_W-1:COUNT_W];
                        ovp_high <= sum32[32];
                    end
                end else begin
                    if (adv_low) begin
                        cnt_low <= step_low[15:0];
                        ovp_low <= step_low[16];
                    end
                    if (adv_high) begin
                        cnt_high <= step_high[15:0];
                        ovp_high <= step_high[16];
                    end
                end
            end
            if (wr_go && waddr == OFS_COUNT_LOW) begin
                cnt_low <= 16'(merge({16'h0000, cnt_low}, wdata, wstrb));
            end
            if (wr_go && waddr == OFS_COUNT_HIGH) begin
                cnt_high <= 16'(merge({16'h0000, cnt_high}, wdata, wstrb));
            end
        end
    end

    // --------------------------------------------------------------
    // Watchdog sequencer
    // --------------------------------------------------------------
    // Next state of the watchdog
    always_comb begin
        next_wd = wd_state;
        case (wd_state)
            WD_IDLE: begin // High overflow arms reset
                if (tick_flag && ovp_high && wd_en) begin
                    next_wd = WD_ARMED;
                end
            end
            WD_ARMED: begin // Reset starts next machine cycle
                if (tick_end) begin
                    next_wd = WD_RESET;
                end
            end
            WD_RESET: begin // Held for five machine cycles
                if (tick_end && wd_cnt == WD_RESET_MC - 3'h1) begin
                    next_wd = WD_IDLE;
                end
            end
            default: begin
                next_wd = WD_IDLE;
            end
        endcase
    end

    // Watchdog state, cycle counter and reset output
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            wd_state <= WD_IDLE;
            wd_cnt <= 3'h0;
            WDOG_RESET <= 1'b0;
        end else begin
            wd_state <= next_wd;
            WDOG_RESET <= (next_wd == WD_RESET);
            if (wd_state != WD_RESET) begin
                wd_cnt <= 3'h0;
            end else if (tick_end) begin
                wd_cnt <= wd_cnt + 3'h1;
            end
        end
    end

    // --------------------------------------------------------------
    // Configuration registers
    // --------------------------------------------------------------
    // Config, mode, run, power-down and mask bits
    always_ff @(posedge CLK_SYS) begin
        if (soft_rst) begin
            io_cfg <= CFG_RESET;
            tmode <= CFG_RESET;
            run_low <= 1'b0;
            run_high <= 1'b0;
            pdn <= 1'b0;
            mask <= 3'h0;
        end else begin
            if (wr_go && waddr == OFS_IO_CONFIG && wstrb[0]) begin
                io_cfg <= wdata[7:0];
            end
            if (wr_go && waddr == OFS_TIMER_MODE && wstrb[0]) begin
                tmode <= wdata[7:0];
            end
            if (wr_go && waddr == OFS_POWER_CTRL && wstrb[0]) begin
                run_low <= wdata[BIT_RUN_LOW];
                run_high <= wdata[BIT_RUN_HIGH];
                pdn <= wdata[BIT_POWER_DOWN];
            end
            if (wr_go && waddr == OFS_MASK && wstrb[0]) begin
                mask <= wdata[2:0];
            end
            if (tick_flag && (ovp_low || ovp_high)) begin
                pdn <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // Status and interrupt
    // --------------------------------------------------------------
    // Write-one-to-clear, hardware set wins over the clear
    always_comb begin
        next_status = status;
        if (wr_go && waddr == OFS_STATUS && wstrb[0]) begin
            next_status = status & ~wdata[2:0];
        end
        if (wd_state == WD_RESET) begin // Overflow flags cleared by watchdog reset
            next_status[ST_OVF_LOW] = 1'b0;
            next_status[ST_OVF_HIGH] = 1'b0;
        end
        if (tick_flag && ovp_low) begin
            next_status[ST_OVF_LOW] = 1'b1;
        end
        if (tick_flag && ovp_high) begin
            next_status[ST_OVF_HIGH] = 1'b1;
        end
        if (next_wd == WD_RESET && wd_state != WD_RESET) begin
            next_status[ST_WD_RESET] = 1'b1;
        end
    end

    // Status register and masked interrupt level
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            status <= 3'h0;
            IRQ <= 1'b0;
        end else begin
            status <= next_status;
            IRQ <= |(next_status & mask);
        end
    end

    // Power-down level shown outside
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            POWER_DOWN <= 1'b0;
        end else begin
            POWER_DOWN <= pdn;
        end
    end

    // --------------------------------------------------------------
    // AXI4-Lite slave
    // --------------------------------------------------------------
    // Write address channel
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            S_AXI_AWREADY <= 1'b0;
            aw_hold <= 1'b0;
            waddr <= 8'h00;
        end else if (S_AXI_AWREADY && S_AXI_AWVALID) begin
            S_AXI_AWREADY <= 1'b0;
            aw_hold <= 1'b1;
            waddr <= {S_AXI_AWADDR[7:2], 2'b00};
        end else if (wr_go) begin
            aw_hold <= 1'b0;
        end else if (!aw_hold && !S_AXI_BVALID) begin
            S_AXI_AWREADY <= 1'b1;
        end
    end

    // Write data channel
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            S_AXI_WREADY <= 1'b0;
            w_hold <= 1'b0;
            wdata <= 32'h00000000;
            wstrb <= 4'h0;
        end else if (S_AXI_WREADY && S_AXI_WVALID) begin
            S_AXI_WREADY <= 1'b0;
            w_hold <= 1'b1;
            wdata <= S_AXI_WDATA;
            wstrb <= S_AXI_WSTRB;
        end else if (wr_go) begin
            w_hold <= 1'b0;
        end else if (!w_hold && !S_AXI_BVALID) begin
            S_AXI_WREADY <= 1'b1;
        end
    end

    // Write response
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else if (wr_go) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= reg_hit(waddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // Read data selection
    always_comb begin
        rd_mux = 32'h00000000;
        case ({S_AXI_ARADDR[7:2], 2'b00})
            OFS_IO_CONFIG: rd_mux[7:0] = io_cfg;
            OFS_TIMER_MODE: rd_mux[7:0] = tmode;
            OFS_POWER_CTRL: rd_mux[2:0] = {pdn, run_high, run_low};
            OFS_COUNT_LOW: rd_mux[15:0] = cnt_low;
            OFS_COUNT_HIGH: rd_mux[15:0] = cnt_high;
            OFS_STATUS: rd_mux[2:0] = status;
            OFS_MASK: rd_mux[2:0] = mask;
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Read address and data channels
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= RESP_OKAY;
        end else if (S_AXI_ARREADY && S_AXI_ARVALID) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_mux;
            S_AXI_RRESP <= reg_hit({S_AXI_ARADDR[7:2], 2'b00}) ?
                           RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end else if (!S_AXI_RVALID && !S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b1;
        end
    end
endmodule // cascaded_timer_watchdog
`default_nettype wire

/* File: verif/ctw_checker_sva.sv */
// Port-level assertions for the cascaded timer and watchdog block
`default_nettype none
module ctw_checker (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic IRQ,
    input wire logic WDOG_RESET,
    input wire logic POWER_DOWN
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------
    // Helper logic
    // ----------------------------------------------------------
    logic [7:0] wd_cnt; // Clocks spent in watchdog reset
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    // Count the length of each watchdog reset
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST || !WDOG_RESET) begin
            wd_cnt <= 8'h00;
        end else begin
            wd_cnt <= wd_cnt + 8'h01;
        end
    end
    // ----------------------------------------------------------
    // Sequences and properties
    // ----------------------------------------------------------
    sequence s_b_take;
        S_AXI_BVALID && S_AXI_BREADY;
    endsequence
    sequence s_wd_hold;
        WDOG_RESET [*3];
    endsequence
    property p_rst_quiet;
        disable iff (1'b0) SYS_RST |=> !IRQ && !WDOG_RESET && !S_AXI_BVALID;
    endproperty
    property p_b_hold;
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID;
    endproperty
    property p_b_done;
        s_b_take |=> !S_AXI_BVALID;
    endproperty
    property p_b_ready;
        $rose(S_AXI_BVALID) |-> !S_AXI_AWREADY && !S_AXI_WREADY;
    endproperty
    property p_r_hold;
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID;
    endproperty
    property p_r_cause;
        $rose(S_AXI_RVALID) |-> $past(S_AXI_ARVALID && S_AXI_ARREADY);
    endproperty
    property p_wd_len;
        $fell(WDOG_RESET) |-> wd_cnt == 8'h3C;
    endproperty
    property p_wd_max;
        wd_cnt <= 8'h3C;
    endproperty
    property p_wd_clear;
        s_wd_hold |-> !IRQ && !POWER_DOWN;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs active after reset");
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    a_b_done: assert property (p_b_done)
        else $error("write response not released");
    a_b_ready: assert property (p_b_ready)
        else $error("write ready high with response");
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped early");
    a_r_cause: assert property (p_r_cause)
        else $error("read data without address");
    a_wd_len: assert property (p_wd_len)
        else $error("watchdog reset length wrong");
    a_wd_max: assert property (p_wd_max)
        else $error("watchdog reset too long");
    a_wd_clear: assert property (p_wd_clear)
        else $error("state not cleared by watchdog");
endmodule // ctw_checker
bind cascaded_timer_watchdog ctw_checker ctw_checker_inst (.*);
`default_nettype wire

/* File: verif/count_source.sv */
// External count signal source for the low count input
`default_nettype none
module count_source (
    input wire logic CLK_SYS,
    output logic count_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle low between pulse trains
    initial count_out = 1'b0;
    // Sends n periods, each level held for half clocks
    task automatic send(input int n, input int half);
        for (int i = 0; i < 2 * n; i++) begin
            count_out <= ~count_out;
            repeat (half) @(posedge CLK_SYS);
        end
    endtask
endmodule // count_source
`default_nettype wire

/* File: verif/tb_cascaded_timer_watchdog.sv */
// Self-checking bench for the cascaded timer and watchdog block
`default_nettype none
module tb_cascaded_timer_watchdog;
    timeunit 1ns;
    timeprecision 1ns;
    import cascade_timer_pkg::*;
    logic clk, rst, awv, wv, bre, arv, rre, awr, wr_r, bv, arr, rv;
    logic irq, wdog, pdn, cin;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdat;
    logic [1:0] bresp, rresp;
    int failures, check_count, cyc;
    cascaded_timer_watchdog cascaded_timer_watchdog_inst (
        .CLK_SYS(clk), .SYS_RST(rst), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rre), .COUNT_IN_LOW(cin), .COUNT_IN_HIGH(1'b0),
        .IRQ(irq), .WDOG_RESET(wdog), .POWER_DOWN(pdn));
    count_source count_source_inst (.CLK_SYS(clk), .count_out(cin));
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            test_done();
        end
    end
    // AXI4-Lite write
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
        end while (!bv);
        r = bresp;
        bre <= 1'b0;
    endtask
    // AXI4-Lite read
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        d = rdat;
        r = rresp;
        rre <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, e);
    endtask
    task automatic wq(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk(32'(r), 32'(RESP_OKAY));
    endtask
    task automatic test_done();
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int n;
        rst = 1'b1;
        awv = 1'b0;
        wv = 1'b0;
        bre = 1'b0;
        arv = 1'b0;
        rre = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) rchk(8'(4 * i), 32'h0);
        wr(8'h1C, 32'h1, r);
        chk(32'(r), 32'(RESP_SLVERR));
        rd(8'h1C, d, r);
        chk({d[29:0], r}, 32'(RESP_SLVERR));
        $display("test reset_map done");
        // Cascade timer wrap timing, flag and interrupt
        wq(OFS_COUNT_LOW, 32'hFFF0);
        wq(OFS_COUNT_HIGH, 32'hFFFF);
        wq(OFS_MASK, 32'h2);
        wq(OFS_IO_CONFIG, 32'h40);
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n >= 175 && n <= 215), 32'h1);
        wq(OFS_IO_CONFIG, 32'h0);
        rchk(OFS_STATUS, 32'h2);
        rchk(OFS_COUNT_HIGH, 32'h0);
        rd(OFS_COUNT_LOW, d, r);
        rchk(OFS_COUNT_LOW, d);
        wq(OFS_MASK, 32'h0);
        @(posedge clk);
        chk(32'(irq), 32'h0);
        wq(OFS_STATUS, 32'h2);
        rchk(OFS_STATUS, 32'h0);
        $display("test cascade_timer done");
        // Non-cascaded run bit starts and stops counting
        wq(OFS_TIMER_MODE, 32'h1);
        wq(OFS_COUNT_LOW, 32'h0);
        wq(OFS_POWER_CTRL, 32'h1);
        repeat (48) @(posedge clk);
        wq(OFS_POWER_CTRL, 32'h0);
        rd(OFS_COUNT_LOW, d, r);
        chk(32'(d != 32'h0), 32'h1);
        rchk(OFS_COUNT_LOW, d);
        $display("test run_bits done");
        // Cascade counter while powered down
        wq(OFS_TIMER_MODE, 32'h4);
        wq(OFS_COUNT_LOW, 32'hFFFB);
        wq(OFS_COUNT_HIGH, 32'hFFFF);
        wq(OFS_MASK, 32'h2);
        wq(OFS_IO_CONFIG, 32'h40);
        wq(OFS_POWER_CTRL, 32'h4);
        count_source_inst.send(5, 12);
        n = 0;
        while (irq !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        chk(32'(irq), 32'h1);
        chk(32'(pdn), 32'h0);
        wq(OFS_IO_CONFIG, 32'h0);
        rchk(OFS_COUNT_LOW, 32'h0);
        rchk(OFS_COUNT_HIGH, 32'h0);
        rchk(OFS_STATUS, 32'h2);
        wq(OFS_STATUS, 32'h2);
        $display("test counter_power_down done");
        // Watchdog overflow resets the timer state
        wq(OFS_TIMER_MODE, 32'h0);
        wq(OFS_COUNT_LOW, 32'hFFF8);
        wq(OFS_COUNT_HIGH, 32'hFFFF);
        wq(OFS_IO_CONFIG, 32'hC0);
        wait (wdog === 1'b1);
        wait (wdog === 1'b0);
        rchk(OFS_IO_CONFIG, 32'h0);
        rchk(OFS_MASK, 32'h0);
        rchk(OFS_COUNT_HIGH, 32'h0);
        rchk(OFS_STATUS, 32'h4);
        wq(OFS_STATUS, 32'h4);
        rchk(OFS_STATUS, 32'h0);
        $display("test watchdog done");
        test_done();
    end
endmodule // tb_cascaded_timer_watchdog
`default_nettype wire
